// ===== hw/mpw_core.sv
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns

module mpw_core #(
  parameter int NUM_PAIRS = 4
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [mpw_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [mpw_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [mpw_pkg::DATA_W-1:0]   reg_rdata,
  output logic      [NUM_PAIRS-1:0]         pair_high_output,
  output logic      [NUM_PAIRS-1:0]         pair_low_output,
  output logic                              timebase_irq_pulse
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (NUM_PAIRS < 1 || NUM_PAIRS > mpw_pkg::MAX_PAIRS) begin : g_bad
      $error("NUM_PAIRS must be 1 to 4");
    end
    if (mpw_pkg::DATA_W < mpw_pkg::DUTY_W) begin : g_bad_bus
      $error("data bus narrower than a duty register");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                           run;
    logic [1:0]                                     mode;
    logic [1:0]                                     presc_sel;
    logic [mpw_pkg::POST_W-1:0]                     post_sel;
    logic [mpw_pkg::CNT_W-1:0]                      cnt;
    logic                                           dir;
    logic [mpw_pkg::PRESC_W-1:0]                    presc_cnt;
    logic [mpw_pkg::POST_W-1:0]                     post_cnt;
    logic [mpw_pkg::CNT_W-1:0]                      per_buf;
    logic [mpw_pkg::CNT_W-1:0]                      per_act;
    logic [NUM_PAIRS-1:0][mpw_pkg::DUTY_W-1:0]      duty_buf;
    logic [NUM_PAIRS-1:0][mpw_pkg::DUTY_W-1:0]      duty_act;
    logic [NUM_PAIRS-1:0]                           indep;
    logic                                           uinh;
    logic                                           immediate_update_enable;
    logic [mpw_pkg::DATA_W-1:0]                     rd_data;
    logic [NUM_PAIRS-1:0]                           out_hi;
    logic [NUM_PAIRS-1:0]                           out_lo;
    logic                                           irq;
  } mpw_state_t;

  mpw_state_t s_reg;
  mpw_state_t s_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [mpw_pkg::PRESC_W-1:0] presc_last_of(
    input logic [1:0] sel
  );
    case (sel)
      2'h0:    presc_last_of = mpw_pkg::PRESC_LAST_1;
      2'h1:    presc_last_of = mpw_pkg::PRESC_LAST_4;
      2'h2:    presc_last_of = mpw_pkg::PRESC_LAST_16;
      default: presc_last_of = mpw_pkg::PRESC_LAST_64;
    endcase
  endfunction

  // Second half of a prescaled count; always 0 at 1:1, so the half
  // step then falls on the next whole count.
  function automatic logic half_of(
    input logic [mpw_pkg::PRESC_W-1:0] pcnt,
    input logic [1:0]                  sel
  );
    half_of = pcnt > (presc_last_of(sel) >> 1);
  endfunction

  function automatic logic edge_active(
    input logic [mpw_pkg::DUTY_W-1:0] duty,
    input logic [mpw_pkg::CNT_W-1:0]  cnt,
    input logic                       half,
    input logic [mpw_pkg::CNT_W-1:0]  per
  );
    edge_active = (duty != mpw_pkg::DUTY_RESET) &&
                  (({cnt, half} < duty) ||
                   (duty[mpw_pkg::DUTY_W-1:1] > per));
  endfunction

  // Active below the duty level: the falling edge is met counting
  // up, the rising edge counting down.
  function automatic logic center_active(
    input logic [mpw_pkg::DUTY_W-1:0] duty,
    input logic [mpw_pkg::CNT_W-1:0]  cnt,
    input logic                       half,
    input logic [mpw_pkg::CNT_W-1:0]  per
  );
    center_active = (duty != mpw_pkg::DUTY_RESET) &&
                    (({cnt, half} < duty) ||
                     (duty[mpw_pkg::DUTY_W-1:1] >= per));
  endfunction

  function automatic logic [mpw_pkg::ADDR_W-1:0] duty_off(input int idx);
    duty_off = mpw_pkg::OFF_DUTY1 +
               8'(idx * int'(mpw_pkg::OFF_DUTY_STEP));
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic                        tick;
  logic                        center;
  logic                        at_period;
  logic                        at_zero;
  logic                        per_ok;
  logic                        wrap_evt;
  logic                        top_evt;
  logic                        zero_evt;
  logic                        evt;
  logic                        use_post;
  logic                        duty_load;
  logic                        half;
  logic                        cmp;
  logic [mpw_pkg::DATA_W-1:0]  rmux;
  mpw_pkg::mpw_mode_t          mode;

  always_comb begin
    s_next    = s_reg;
    s_next.irq     = 1'b0;
    s_next.rd_data = '0;
    mode      = mpw_pkg::mpw_mode_t'(s_reg.mode);
    center    = (mode == mpw_pkg::MODE_UPDOWN) ||
                (mode == mpw_pkg::MODE_DOUBLE);
    tick      = s_reg.run &&
                (s_reg.presc_cnt == presc_last_of(s_reg.presc_sel));
    at_period = s_reg.cnt == s_reg.per_act;
    at_zero   = s_reg.cnt == '0;
    // A zero period parks the counter and silences every event
    per_ok    = s_reg.per_act != '0;
    wrap_evt  = 1'b0;
    top_evt   = 1'b0;
    zero_evt  = 1'b0;

    // Time base
    if (s_reg.run) begin
      s_next.presc_cnt = tick ? '0 : s_reg.presc_cnt + 6'h01;
    end
    if (tick && per_ok) begin
      if (!center) begin
        if (at_period) begin
          s_next.cnt = '0;
          wrap_evt   = 1'b1;
          if (mode == mpw_pkg::MODE_SINGLE) begin
            s_next.run = 1'b0;
          end
        end else begin
          s_next.cnt = s_reg.cnt + 15'h0001;
        end
      end else if (!s_reg.dir) begin
        if (at_period) begin
          s_next.dir = 1'b1;
          s_next.cnt = s_reg.cnt - 15'h0001;
          top_evt    = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 15'h0001;
        end
      end else begin
        if (at_zero) begin
          s_next.dir = 1'b0;
          s_next.cnt = s_reg.cnt + 15'h0001;
          zero_evt   = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 15'h0001;
        end
      end
    end

    // Edge modes only count up; without this a down flag left over
    // from an up/down run would read back as counting down
    if (!center) begin
      s_next.dir = 1'b0;
    end

    // Interrupt events
    case (mode)
      mpw_pkg::MODE_FREE:   evt = wrap_evt;
      mpw_pkg::MODE_SINGLE: evt = wrap_evt;
      mpw_pkg::MODE_UPDOWN: evt = zero_evt;
      default:              evt = zero_evt || top_evt;
    endcase
    use_post = (mode == mpw_pkg::MODE_FREE) ||
               (mode == mpw_pkg::MODE_UPDOWN);
    if (evt) begin
      if (!use_post) begin
        s_next.irq = 1'b1;
      end else if (s_reg.post_cnt == s_reg.post_sel) begin
        s_next.post_cnt = '0;
        s_next.irq      = 1'b1;
      end else begin
        s_next.post_cnt = s_reg.post_cnt + 4'h1;
      end
    end

    // Period buffer transfer
    // While running, a new period never cuts the current one short
    if (!s_reg.run) begin
      s_next.per_act = s_reg.per_buf;
    end else if ((!center && wrap_evt) || (center && zero_evt)) begin
      s_next.per_act = s_reg.per_buf;
    end

    // Duty buffer transfer
    // Inhibit only matters while stopped in the edge modes; a running period still loads
    if (!center) begin
      duty_load = s_reg.run ? wrap_evt : !s_reg.uinh;
    end else if (mode == mpw_pkg::MODE_DOUBLE) begin
      duty_load = s_reg.run ? (zero_evt || top_evt) : 1'b1;
    end else begin
      duty_load = s_reg.run ? zero_evt : 1'b1;
    end
    if (duty_load) begin
      s_next.duty_act = s_reg.duty_buf;
    end

    // Register writes take effect over the timing updates above
    if (reg_wr) begin
      case (reg_addr)
        mpw_pkg::OFF_CTRL: begin
          // Software run write wins over the single-shot self-clear
          s_next.run       = reg_wdata[mpw_pkg::CTRL_RUN_BIT];
          s_next.mode      = reg_wdata[mpw_pkg::CTRL_MODE_LSB +: 2];
          s_next.presc_sel = reg_wdata[mpw_pkg::CTRL_PRESC_LSB +: 2];
          s_next.post_sel  =
            reg_wdata[mpw_pkg::CTRL_POST_LSB +: mpw_pkg::POST_W];
          s_next.presc_cnt = '0;
          s_next.post_cnt  = '0;
        end
        mpw_pkg::OFF_COUNT: begin
          s_next.cnt       = reg_wdata[mpw_pkg::CNT_W-1:0];
          s_next.presc_cnt = '0;
          s_next.post_cnt  = '0;
        end
        mpw_pkg::OFF_PERIOD: begin
          s_next.per_buf = reg_wdata[mpw_pkg::CNT_W-1:0];
        end
        mpw_pkg::OFF_OUT1: begin
          s_next.indep = reg_wdata[NUM_PAIRS-1:0];
        end
        mpw_pkg::OFF_OUT2: begin
          s_next.uinh = reg_wdata[mpw_pkg::OUT2_UINH_BIT];
          s_next.immediate_update_enable  = reg_wdata[mpw_pkg::OUT2_IUE_BIT];
        end
        default: begin
        end
      endcase
      for (int i = 0; i < NUM_PAIRS; i++) begin
        if (reg_addr == duty_off(i)) begin
          s_next.duty_buf[i] = reg_wdata;
          if (s_reg.immediate_update_enable) begin
            s_next.duty_act[i] = reg_wdata;
          end
        end
      end
    end

    // Read data, valid only in the cycle after the strobe
    rmux = '0;
    case (reg_addr)
      mpw_pkg::OFF_CTRL: begin
        rmux[mpw_pkg::CTRL_RUN_BIT]                    = s_reg.run;
        rmux[mpw_pkg::CTRL_MODE_LSB +: 2]              = s_reg.mode;
        rmux[mpw_pkg::CTRL_PRESC_LSB +: 2]             = s_reg.presc_sel;
        rmux[mpw_pkg::CTRL_POST_LSB +: mpw_pkg::POST_W] = s_reg.post_sel;
      end
      mpw_pkg::OFF_COUNT: begin
        rmux[mpw_pkg::CNT_W-1:0]     = s_reg.cnt;
        rmux[mpw_pkg::COUNT_DIR_BIT] = s_reg.dir;
      end
      mpw_pkg::OFF_PERIOD: begin
        rmux[mpw_pkg::CNT_W-1:0] = s_reg.per_buf;
      end
      mpw_pkg::OFF_OUT1: begin
        rmux[NUM_PAIRS-1:0] = s_reg.indep;
      end
      mpw_pkg::OFF_OUT2: begin
        rmux[mpw_pkg::OUT2_UINH_BIT] = s_reg.uinh;
        rmux[mpw_pkg::OUT2_IUE_BIT]  = s_reg.immediate_update_enable;
      end
      default: begin
      end
    endcase
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (reg_addr == duty_off(i)) begin
        rmux = s_reg.duty_buf[i];
      end
    end
    if (reg_rd) begin
      s_next.rd_data = rmux;
    end

    // Outputs follow the state being registered this edge, so a duty
    // written with immediate update moves the edge at once
    half = half_of(s_next.presc_cnt, s_next.presc_sel);
    cmp  = 1'b0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (center) begin
        cmp = center_active(s_next.duty_act[i], s_next.cnt, half,
                            s_next.per_act);
      end else begin
        cmp = edge_active(s_next.duty_act[i], s_next.cnt, half,
                          s_next.per_act);
        // A finished single shot leaves the high pins inactive; complementary low pins then sit high
        if (mode == mpw_pkg::MODE_SINGLE && !s_next.run) begin
          cmp = 1'b0;
        end
      end
      s_next.out_hi[i] = cmp;
      s_next.out_lo[i] = s_next.indep[i] ? cmp : !cmp;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg           <= '0;
      s_reg.per_buf   <= mpw_pkg::PERIOD_RESET;
      s_reg.per_act   <= mpw_pkg::PERIOD_RESET;
      s_reg.indep     <= NUM_PAIRS'(mpw_pkg::PAIR_SEL_RESET);
      // Complementary default: low pins start as the inverse
      s_reg.out_lo    <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata          = s_reg.rd_data;
  assign pair_high_output   = s_reg.out_hi;
  assign pair_low_output    = s_reg.out_lo;
  assign timebase_irq_pulse = s_reg.irq;

endmodule // mpw_core

// ===== hw/mpw_pkg.sv
package mpw_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_DUTY1  = 8'h0c;
  localparam logic [7:0] OFF_DUTY_STEP = 8'h04;
  localparam logic [7:0] OFF_OUT1   = 8'h1c;
  localparam logic [7:0] OFF_OUT2   = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_PRESC_LSB = 2;
  localparam int CTRL_POST_LSB  = 4;
  localparam int CTRL_RUN_BIT   = 15;
  localparam int COUNT_DIR_BIT  = 15;
  localparam int OUT2_UINH_BIT  = 0;
  localparam int OUT2_IUE_BIT   = 1;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int CNT_W   = 15;
  localparam int DUTY_W  = 16;
  localparam int PRESC_W = 6;
  localparam int POST_W  = 4;
  localparam int MAX_PAIRS = 4;

  localparam logic [CNT_W-1:0]  PERIOD_RESET = 15'h0000;
  localparam logic [DUTY_W-1:0] DUTY_RESET   = 16'h0000;
  localparam logic [3:0]        PAIR_SEL_RESET = 4'h0;

  // Last prescaler count for 1:1, 1:4, 1:16, 1:64
  localparam logic [PRESC_W-1:0] PRESC_LAST_1  = 6'h00;
  localparam logic [PRESC_W-1:0] PRESC_LAST_4  = 6'h03;
  localparam logic [PRESC_W-1:0] PRESC_LAST_16 = 6'h0f;
  localparam logic [PRESC_W-1:0] PRESC_LAST_64 = 6'h3f;

  typedef enum logic [1:0] {
    MODE_FREE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_UPDOWN = 2'h2,
    MODE_DOUBLE = 2'h3
  } mpw_mode_t;

endpackage

// ===== bench/mpw_bridge_model.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Power bridge legs seen by the pair outputs
// ----------------------------------------------------------------
module mpw_bridge_model (
  input  wire logic [3:0] high_drive,
  input  wire logic [3:0] low_drive,
  output logic            shoot_through
);
  // Both switches of one leg on shorts the supply rail
  assign shoot_through = |(high_drive & low_drive);
endmodule // mpw_bridge_model

// ===== bench/mpw_core_chk.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Port checker, shadows the run bit, period, first duty and pair select registers
// ----------------------------------------------------------------
module mpw_core_chk #(
  parameter int NUM_PAIRS = 4
) (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic [mpw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mpw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [mpw_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [NUM_PAIRS-1:0]       pair_high_output,
  input wire logic [NUM_PAIRS-1:0]       pair_low_output,
  input wire logic                       timebase_irq_pulse
);
  typedef struct packed {
    logic [3:0]  sel;
    logic [3:0]  sel_old;
    logic        run;
    logic [14:0] per;
    logic [15:0] duty;
  } mpw_shadow_t;

  mpw_shadow_t sh_reg;
  mpw_shadow_t sh_next;

  // Run shadow only errs towards running, so it is safe as a gate
  always_comb begin
    sh_next = sh_reg;
    sh_next.sel_old = sh_reg.sel;
    if (reg_wr && reg_addr == mpw_pkg::OFF_CTRL) sh_next.run = reg_wdata[15];
    if (reg_wr && reg_addr == mpw_pkg::OFF_PERIOD)
      sh_next.per = reg_wdata[14:0];
    if (reg_wr && reg_addr == mpw_pkg::OFF_DUTY1) sh_next.duty = reg_wdata;
    if (reg_wr && reg_addr == mpw_pkg::OFF_OUT1) sh_next.sel = reg_wdata[3:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) sh_reg <= '0;
    else sh_reg <= sh_next;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_RESET_OUT: assert property (
    $fell(reset) |-> pair_high_output == '0 && pair_low_output == '1
    && !timebase_irq_pulse) else $error("bad reset state");
  AST_PAIR_COMP: assert property (sh_reg.sel == sh_reg.sel_old |->
    pair_low_output == (pair_high_output ^ ~sh_reg.sel[NUM_PAIRS-1:0]))
    else $error("pair low wrong");
  AST_IRQ_ONE: assert property (
    timebase_irq_pulse |=> !timebase_irq_pulse)
    else $error("irq longer than one clock");
  AST_IRQ_STOPPED: assert property (!sh_reg.run && !$past(sh_reg.run)
    |-> !timebase_irq_pulse) else $error("irq while stopped");
  AST_PERIOD_RB: assert property (
    reg_rd && reg_addr == mpw_pkg::OFF_PERIOD
    |=> reg_rdata == {1'b0, sh_reg.per}) else $error("period readback");
  AST_DUTY_RB: assert property (
    reg_rd && reg_addr == mpw_pkg::OFF_DUTY1
    |=> reg_rdata == sh_reg.duty) else $error("duty readback");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > mpw_pkg::OFF_OUT2
    |=> reg_rdata == '0) else $error("unmapped read");

  COV_IRQ: cover property (timebase_irq_pulse);
  COV_INDEP: cover property (|(pair_high_output & pair_low_output));
  COV_COUNT_RD: cover property (reg_rd && reg_addr == mpw_pkg::OFF_COUNT);
endmodule // mpw_core_chk

bind mpw_core mpw_core_chk #(.NUM_PAIRS(NUM_PAIRS)) chk_i (.clk(clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair_high_output(pair_high_output),
  .pair_low_output(pair_low_output), .timebase_irq_pulse(timebase_irq_pulse));

// ===== bench/testbench.sv
`timescale 1ns/1ns

module testbench;
  logic        clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  ph;
  logic [3:0]  pl;
  logic        irq;
  logic        shoot;
  logic [15:0] q;
  int          error_cnt;
  int          n_checks;
  int          ic;
  int          sc;
  int          hc [4];

  mpw_core uut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pair_high_output(ph), .pair_low_output(pl),
    .timebase_irq_pulse(irq));
  mpw_bridge_model leg (.high_drive(ph), .low_drive(pl),
    .shoot_through(shoot));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus, compare and measuring helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  // A spare cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    #1 reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    #1 reg_rd <= 1'b0;
    q = reg_rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic dset(input logic [15:0] v [4]);
    for (int i = 0; i < 4; i++) wr(mpw_pkg::OFF_DUTY1 + 8'(4 * i), v[i]);
  endtask

  // Whole periods only, so the count does not depend on phase
  task automatic meas(input int n);
    hc = '{0, 0, 0, 0};
    ic = 0;
    sc = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) hc[i] += int'(ph[i] === 1'b1);
      ic += int'(irq === 1'b1);
      sc += int'(shoot === 1'b1);
    end
  endtask

  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 400) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk({12'h000, pl}, 16'h000f);
    wr(mpw_pkg::OFF_PERIOD, 16'hffff);
    rd(mpw_pkg::OFF_PERIOD);
    chk(q, 16'h7fff);
    dset('{16'hc3a0, 16'hc3a1, 16'hc3a2, 16'hc3a3});
    for (int i = 0; i < 4; i++) begin
      rd(mpw_pkg::OFF_DUTY1 + 8'(4 * i));
      chk(q, 16'hc3a0 + 16'(i));
    end
    wr(mpw_pkg::OFF_COUNT, 16'h8005);
    wr(mpw_pkg::OFF_CTRL, 16'h0000);
    rd(mpw_pkg::OFF_COUNT);
    chk(q, 16'h0005);
    rd(8'h40);
    chk(q, 16'h0000);
  endtask

  task automatic t_edge();
    wr(mpw_pkg::OFF_COUNT, 16'h0000);
    wr(mpw_pkg::OFF_PERIOD, 16'h0002);
    dset('{16'h0004, 16'h0000, 16'h0006, 16'h0003});
    wr(mpw_pkg::OFF_OUT2, 16'h0000);
    wr(mpw_pkg::OFF_CTRL, 16'h8000);
    meas(30);
    chk(16'(hc[0]), 16'd20);
    chk(16'(hc[1]), 16'd0);
    chk(16'(hc[2]), 16'd30);
    chk(16'(ic), 16'd10);
    chk(16'(sc), 16'd0);
  endtask

  task automatic t_scale();
    int r;
    int s;
    for (int k = 0; k < 4; k++) begin
      r = 1 << (2 * k);
      wr(mpw_pkg::OFF_CTRL, 16'h8000 | 16'(k << 2));
      meas(6 * r);
      chk(16'(ic), 16'd2);
      chk(16'(hc[0]), 16'(4 * r));
      chk(16'(hc[3]), 16'(k == 0 ? 4 : 3 * r));
    end
    for (int o = 0; o < 16; o++) begin
      wr(mpw_pkg::OFF_CTRL, 16'h8000 | 16'(o << 4));
      meas(6 * (o + 1));
      chk(16'(ic), 16'd2);
    end
    s = 0;
    repeat (4) begin
      wr(mpw_pkg::OFF_CTRL, 16'h8030);
      meas(6);
      s += ic;
    end
    chk(16'(s), 16'd0);
  endtask

  task automatic t_center();
    logic [15:0] m [4] = '{16'h8002, 16'h8003, 16'h8032, 16'h8033};
    logic [15:0] e [4] = '{16'd4, 16'd8, 16'd1, 16'd8};
    wr(mpw_pkg::OFF_CTRL, 16'h0000);
    wr(mpw_pkg::OFF_COUNT, 16'h0000);
    wr(mpw_pkg::OFF_PERIOD, 16'h0004);
    dset('{16'h0004, 16'h0008, 16'h0000, 16'h0007});
    for (int i = 0; i < 4; i++) begin
      wr(mpw_pkg::OFF_CTRL, m[i]);
      meas(32);
      chk(16'(ic), e[i]);
    end
    chk(16'(hc[0]), 16'd12);
    chk(16'(hc[1]), 16'd32);
    chk(16'(hc[2]), 16'd0);
    chk(16'(hc[3]), 16'd28);
    wr(mpw_pkg::OFF_CTRL, 16'h0000);
    wr(mpw_pkg::OFF_COUNT, 16'h0004);
    wr(mpw_pkg::OFF_CTRL, 16'h8002);
    rd(mpw_pkg::OFF_COUNT);
    chk(q, 16'h8003);
  endtask

  task automatic t_single();
    wr(mpw_pkg::OFF_CTRL, 16'h0000);
    wr(mpw_pkg::OFF_COUNT, 16'h0000);
    wr(mpw_pkg::OFF_PERIOD, 16'h0003);
    wr(mpw_pkg::OFF_CTRL, 16'h8001);
    meas(20);
    chk(16'(ic), 16'd1);
    chk({12'h000, ph}, 16'h0000);
    rd(mpw_pkg::OFF_CTRL);
    chk(q, 16'h0001);
    rd(mpw_pkg::OFF_COUNT);
    chk(q, 16'h0000);
  endtask

  task automatic t_imm();
    wr(mpw_pkg::OFF_CTRL, 16'h0000);
    wr(mpw_pkg::OFF_COUNT, 16'h0000);
    wr(mpw_pkg::OFF_PERIOD, 16'h0009);
    wr(mpw_pkg::OFF_DUTY1, 16'h0000);
    wr(mpw_pkg::OFF_OUT2, 16'h0001);
    wr(mpw_pkg::OFF_DUTY1, 16'h0014);
    chk({15'h0000, ph[0]}, 16'h0000);
    wr(mpw_pkg::OFF_OUT2, 16'h0000);
    chk({15'h0000, ph[0]}, 16'h0001);
    wr(mpw_pkg::OFF_DUTY1, 16'h0000);
    wr(mpw_pkg::OFF_CTRL, 16'h8000);
    wirq();
    wr(mpw_pkg::OFF_DUTY1, 16'h0014);
    chk({15'h0000, ph[0]}, 16'h0000);
    wirq();
    meas(20);
    chk(16'(hc[0]), 16'd20);
    wr(mpw_pkg::OFF_OUT2, 16'h0002);
    wr(mpw_pkg::OFF_DUTY1, 16'h0000);
    chk({15'h0000, ph[0]}, 16'h0000);
    wr(mpw_pkg::OFF_DUTY1, 16'h0014);
    chk({15'h0000, ph[0]}, 16'h0001);
    wirq();
    meas(4);
    wr(mpw_pkg::OFF_DUTY1, 16'h0004);
    chk({15'h0000, ph[0]}, 16'h0000);
    wr(mpw_pkg::OFF_DUTY1, 16'h0012);
    chk({15'h0000, ph[0]}, 16'h0001);
    wr(mpw_pkg::OFF_OUT1, 16'h0001);
    chk({15'h0000, pl[0]}, 16'h0001);
    wirq();
    wr(mpw_pkg::OFF_PERIOD, 16'h0004);
    meas(13);
    chk(16'(ic), 16'd2);
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_regs();
    t_edge();
    t_scale();
    t_center();
    t_single();
    t_imm();
    wrap_up();
  end
endmodule // testbench
